// [bcc_regs.vh]
`ifndef BCC_REGS_VH
`define BCC_REGS_VH

// ==========================================================
// register byte offsets
`define BCC_OFF_MODE 8'h00
`define BCC_OFF_HFMT 8'h04
`define BCC_OFF_TIME 8'h08
`define BCC_OFF_CAL 8'h0c
`define BCC_OFF_TALM 8'h10
`define BCC_OFF_CALM 8'h14
`define BCC_OFF_STAT 8'h18
`define BCC_OFF_SCLR 8'h1c
`define BCC_OFF_IEN 8'h20
`define BCC_OFF_IDIS 8'h24
`define BCC_OFF_IMSK 8'h28
`define BCC_OFF_VER 8'h2c

// ==========================================================
// reset values and write masks
`define BCC_RST_ZERO 32'h00000000
`define BCC_RST_CAL 32'h01819819
`define BCC_MASK_MODE 32'h00030303
`define BCC_MASK_TALM 32'h00ffffff
`define BCC_MASK_CALM 32'hbf9f0000

// ==========================================================
// mode register fields
`define BCC_MODE_UPD_TIME 0
`define BCC_MODE_UPD_CAL 1
`define BCC_MODE_TEV_LO 8
`define BCC_MODE_CEV_LO 16

// ==========================================================
// time / calendar / alarm field positions
`define BCC_SEC_LO 0
`define BCC_MIN_LO 8
`define BCC_HOUR_LO 16
`define BCC_MER_BIT 22
`define BCC_SEC_EN 7
`define BCC_MIN_EN 15
`define BCC_HOUR_EN 23
`define BCC_CENTURY_FIELD_LO 0
`define BCC_YEAR_LO 8
`define BCC_MON_LO 16
`define BCC_WDAY_LO 21
`define BCC_DATE_LO 24
`define BCC_MON_EN 23
`define BCC_DATE_EN 31

// ==========================================================
// status bits and entry error bits
`define BCC_ST_ACK 0
`define BCC_ST_ALARM 1
`define BCC_ST_SEC 2
`define BCC_ST_TEV 3
`define BCC_ST_CEV 4
`define BCC_VER_TIME 0
`define BCC_VER_CAL 1
`define BCC_VER_TALM 2
`define BCC_VER_CALM 3

// ==========================================================
// event selector codes
`define BCC_TEV_MIN 2'h0
`define BCC_TEV_HOUR 2'h1
`define BCC_TEV_MIDN 2'h2
`define BCC_TEV_NOON 2'h3
`define BCC_CEV_WEEK 2'h0
`define BCC_CEV_MONTH 2'h1
`define BCC_CEV_YEAR 2'h2

// ==========================================================
// timing
`define BCC_SEC_NS 1000000000
`define BCC_CLK_NS 4
`define BCC_TICK_CYCLES (`BCC_SEC_NS / `BCC_CLK_NS)

`endif

// [bcc_sec_tick.v]
`timescale 1ns/1ps
`include "bcc_regs.vh"

module bcc_sec_tick #(
   parameter CYCLES = `BCC_TICK_CYCLES
)(
   input wire core_clk_i,
   input wire rst_n_i,
   input wire en_i,
   output wire tick_o
);

   localparam [31:0] LAST32 = CYCLES - 1;
   localparam [27:0] LAST = LAST32[27:0];

   reg [27:0] cnt_q;
   reg tick_q;

   // ==========================================================
   // free running one second prescaler
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 28'h0000000;
         tick_q <= 1'b0;
      end
      else if (en_i)
      begin
         if (cnt_q == LAST)
         begin
            cnt_q <= 28'h0000000;
            tick_q <= 1'b1;
         end
         else
         begin
            cnt_q <= cnt_q + 28'h0000001;
            tick_q <= 1'b0;
         end
      end
   end

   assign tick_o = tick_q;

endmodule

// [bcc_calendar_clock.v]
`timescale 1ns/1ps
`include "bcc_regs.vh"

module bcc_calendar_clock #(
   parameter TICK_CYCLES = `BCC_TICK_CYCLES
)(
   input wire core_clk_i,
   input wire rst_n_i,
   input wire en_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output wire [31:0] rdata_o
);

   // ==========================================================
   // bcd helpers
   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   function bcd_ok;
      input [7:0] v;
      input [7:0] lo;
      input [7:0] hi;
      begin
         bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
      end
   endfunction

   // every fourth year leaps, valid up to 2099
   function is_leap;
      input [7:0] y;
      begin
         if (y[4])
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
         else
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end
   endfunction

   function [7:0] month_days;
      input [7:0] m;
      input leap;
      begin
         case (m)
            8'h02: month_days = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
            default: month_days = 8'h31;
         endcase
      end
   endfunction

   // hour check depends on format and meridiem
   function hour_ok;
      input [7:0] h;
      input mer;
      input fmt12;
      begin
         if (fmt12)
            hour_ok = bcd_ok(h, 8'h01, 8'h12);
         else
            hour_ok = bcd_ok(h, 8'h00, 8'h23) && !mer;
      end
   endfunction

   // ==========================================================
   // state
   reg [31:0] mode_q;
   reg hfmt_q;
   reg [6:0] sec_q;
   reg [6:0] min_q;
   reg [5:0] hour_q;
   reg mer_q;
   reg [6:0] century_field_q;
   reg [7:0] year_q;
   reg [4:0] mon_q;
   reg [2:0] wday_q;
   reg [5:0] date_q;
   reg [31:0] talm_q;
   reg [31:0] calm_q;
   reg [4:0] stat_q;
   reg [4:0] imsk_q;
   reg [3:0] ver_q;
   reg [31:0] rdata_q;

   reg [6:0] sec_n;
   reg [6:0] min_n;
   reg [5:0] hour_n;
   reg mer_n;
   reg [6:0] century_field_n;
   reg [7:0] year_n;
   reg [4:0] mon_n;
   reg [2:0] wday_n;
   reg [5:0] date_n;
   reg [7:0] inc_t;
   reg min_chg;
   reg hr_chg;
   reg day_chg;
   reg noon;
   reg tev_hit;
   reg cev_hit;
   reg alarm_hit;
   reg [4:0] stat_set;
   reg [31:0] rdata_d;

   wire tick;
   wire upd_time = mode_q[`BCC_MODE_UPD_TIME];
   wire upd_cal = mode_q[`BCC_MODE_UPD_CAL];
   wire [1:0] tev_sel = mode_q[`BCC_MODE_TEV_LO+1:`BCC_MODE_TEV_LO];
   wire [1:0] cev_sel = mode_q[`BCC_MODE_CEV_LO+1:`BCC_MODE_CEV_LO];
   wire wr_mode = wr_i && (addr_i == `BCC_OFF_MODE);
   wire wr_time = wr_i && (addr_i == `BCC_OFF_TIME) && upd_time;
   wire wr_cal = wr_i && (addr_i == `BCC_OFF_CAL) && upd_cal;
   wire wr_talm = wr_i && (addr_i == `BCC_OFF_TALM);
   wire wr_calm = wr_i && (addr_i == `BCC_OFF_CALM);
   wire [31:0] w = wdata_i;
   wire [31:0] time_rd = {9'h000, mer_q, hour_q, 1'b0, min_q, 1'b0, sec_q};
   wire [31:0] cal_rd = {2'h0, date_q, wday_q, mon_q, year_q, 1'b0, century_field_q};

   // ==========================================================
   // entry checks
   wire w_fmt12 = hfmt_q;
   wire time_ok = bcd_ok({1'b0, w[6:0]}, 8'h00, 8'h59)
      && bcd_ok({1'b0, w[14:8]}, 8'h00, 8'h59)
      && hour_ok({2'h0, w[21:16]}, w[`BCC_MER_BIT], w_fmt12);
   wire talm_ok = bcd_ok({1'b0, w[6:0]}, 8'h00, 8'h59)
      && bcd_ok({1'b0, w[14:8]}, 8'h00, 8'h59)
      && hour_ok({2'h0, w[21:16]}, w[`BCC_MER_BIT], w_fmt12);
   wire cal_ok = bcd_ok({1'b0, w[6:0]}, 8'h19, 8'h20)
      && bcd_ok(w[15:8], 8'h00, 8'h99)
      && bcd_ok({3'h0, w[20:16]}, 8'h01, 8'h12)
      && bcd_ok({5'h00, w[23:21]}, 8'h01, 8'h07)
      && bcd_ok({2'h0, w[29:24]}, 8'h01, 8'h31)
      && ({2'h0, w[29:24]} <= month_days({3'h0, w[20:16]}, is_leap(w[15:8])));
   wire calm_ok = bcd_ok({3'h0, w[20:16]}, 8'h01, 8'h12)
      && bcd_ok({2'h0, w[29:24]}, 8'h01, 8'h31);

   bcc_sec_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .en_i(en_i),
      .tick_o(tick)
   );

   // ==========================================================
   // counter advance
   always @*
   begin
      sec_n = sec_q;
      min_n = min_q;
      hour_n = hour_q;
      mer_n = mer_q;
      century_field_n = century_field_q;
      year_n = year_q;
      mon_n = mon_q;
      wday_n = wday_q;
      date_n = date_q;
      inc_t = 8'h00;
      min_chg = 1'b0;
      hr_chg = 1'b0;
      day_chg = 1'b0;
      noon = 1'b0;
      if (tick && !upd_time)
      begin
         if (sec_q == 7'h59)
         begin
            sec_n = 7'h00;
            min_chg = 1'b1;
            if (min_q == 7'h59)
            begin
               min_n = 7'h00;
               hr_chg = 1'b1;
               inc_t = bcd_inc({2'h0, hour_q});
               if (hfmt_q)
               begin
                  if (hour_q == 6'h12)
                     hour_n = 6'h01;
                  else if (hour_q == 6'h11)
                  begin
                     hour_n = 6'h12;
                     mer_n = !mer_q;
                     day_chg = mer_q;
                     noon = !mer_q;
                  end
                  else
                     hour_n = inc_t[5:0];
               end
               else if (hour_q == 6'h23)
               begin
                  hour_n = 6'h00;
                  day_chg = 1'b1;
               end
               else
               begin
                  hour_n = inc_t[5:0];
                  noon = (hour_q == 6'h11);
               end
            end
            else
            begin
               inc_t = bcd_inc({1'b0, min_q});
               min_n = inc_t[6:0];
            end
         end
         else
         begin
            inc_t = bcd_inc({1'b0, sec_q});
            sec_n = inc_t[6:0];
         end
      end
      // time keeps running while the calendar is held, so days may be lost
      if (day_chg && !upd_cal)
      begin
         wday_n = (wday_q == 3'h7) ? 3'h1 : wday_q + 3'h1;
         if ({2'h0, date_q} >= month_days({3'h0, mon_q}, is_leap(year_q)))
         begin
            date_n = 6'h01;
            if (mon_q == 5'h12)
            begin
               mon_n = 5'h01;
               year_n = bcd_inc(year_q);
               if (year_q == 8'h99)
               begin
                  year_n = 8'h00;
                  century_field_n = (century_field_q == 7'h19) ? 7'h20 : 7'h19;
               end
            end
            else
            begin
               inc_t = bcd_inc({3'h0, mon_q});
               mon_n = inc_t[4:0];
            end
         end
         else
         begin
            inc_t = bcd_inc({2'h0, date_q});
            date_n = inc_t[5:0];
         end
      end
   end

   // ==========================================================
   // events and alarm
   always @*
   begin
      case (tev_sel)
         `BCC_TEV_MIN: tev_hit = min_chg;
         `BCC_TEV_HOUR: tev_hit = hr_chg;
         `BCC_TEV_MIDN: tev_hit = day_chg;
         `BCC_TEV_NOON: tev_hit = noon;
         default: tev_hit = 1'b0;
      endcase
      case (cev_sel)
         `BCC_CEV_WEEK: cev_hit = day_chg && (wday_n == 3'h1);
         `BCC_CEV_MONTH: cev_hit = day_chg && (date_n == 6'h01);
         `BCC_CEV_YEAR: cev_hit = day_chg && (date_n == 6'h01) && (mon_n == 5'h01);
         default: cev_hit = 1'b0;
      endcase
      if (upd_cal)
         cev_hit = 1'b0;
      alarm_hit = tick && !upd_time
         && (talm_q[`BCC_SEC_EN] || talm_q[`BCC_MIN_EN] || talm_q[`BCC_HOUR_EN]
            || calm_q[`BCC_MON_EN] || calm_q[`BCC_DATE_EN])
         && (!talm_q[`BCC_SEC_EN] || (talm_q[6:0] == sec_n))
         && (!talm_q[`BCC_MIN_EN] || (talm_q[14:8] == min_n))
         && (!talm_q[`BCC_HOUR_EN] || (talm_q[22:16] == {mer_n, hour_n}))
         && (!calm_q[`BCC_MON_EN] || (calm_q[20:16] == mon_n))
         && (!calm_q[`BCC_DATE_EN] || (calm_q[29:24] == date_n));
      stat_set = 5'h00;
      stat_set[`BCC_ST_ACK] = wr_mode && ((w[1:0] & ~mode_q[1:0]) != 2'h0);
      stat_set[`BCC_ST_ALARM] = alarm_hit;
      stat_set[`BCC_ST_SEC] = tick && !upd_time;
      stat_set[`BCC_ST_TEV] = tev_hit;
      stat_set[`BCC_ST_CEV] = cev_hit;
   end

   // ==========================================================
   // registers
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         mode_q <= `BCC_RST_ZERO;
         hfmt_q <= 1'b0;
         sec_q <= 7'h00;
         min_q <= 7'h00;
         hour_q <= 6'h00;
         mer_q <= 1'b0;
         century_field_q <= 7'h19;
         year_q <= 8'h98;
         mon_q <= 5'h01;
         wday_q <= 3'h4;
         date_q <= 6'h01;
         talm_q <= `BCC_RST_ZERO;
         calm_q <= `BCC_RST_ZERO;
         stat_q <= 5'h00;
         imsk_q <= 5'h00;
         ver_q <= 4'h0;
         rdata_q <= `BCC_RST_ZERO;
      end
      else if (en_i)
      begin
         sec_q <= sec_n;
         min_q <= min_n;
         hour_q <= hour_n;
         mer_q <= mer_n;
         century_field_q <= century_field_n;
         year_q <= year_n;
         mon_q <= mon_n;
         wday_q <= wday_n;
         date_q <= date_n;
         if (wr_mode)
            mode_q <= w & `BCC_MASK_MODE;
         if (wr_i && (addr_i == `BCC_OFF_HFMT))
            hfmt_q <= w[0];
         if (wr_time)
         begin
            ver_q[`BCC_VER_TIME] <= !time_ok;
            if (time_ok)
            begin
               sec_q <= w[6:0];
               min_q <= w[14:8];
               hour_q <= w[21:16];
               mer_q <= w[`BCC_MER_BIT];
            end
         end
         if (wr_cal)
         begin
            ver_q[`BCC_VER_CAL] <= !cal_ok;
            if (cal_ok)
            begin
               century_field_q <= w[6:0];
               year_q <= w[15:8];
               mon_q <= w[20:16];
               wday_q <= w[23:21];
               date_q <= w[29:24];
            end
         end
         if (wr_talm)
         begin
            ver_q[`BCC_VER_TALM] <= !talm_ok;
            if (talm_ok)
               talm_q <= w & `BCC_MASK_TALM;
         end
         if (wr_calm)
         begin
            ver_q[`BCC_VER_CALM] <= !calm_ok;
            if (calm_ok)
               calm_q <= w & `BCC_MASK_CALM;
         end
         // an event in the clearing cycle survives
         if (wr_i && (addr_i == `BCC_OFF_SCLR))
            stat_q <= (stat_q & ~w[4:0]) | stat_set;
         else
            stat_q <= stat_q | stat_set;
         if (wr_i && (addr_i == `BCC_OFF_IEN))
            imsk_q <= imsk_q | w[4:0];
         if (wr_i && (addr_i == `BCC_OFF_IDIS))
            imsk_q <= imsk_q & ~w[4:0];
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // read mux, zero outside the answer cycle
   always @*
   begin
      rdata_d = `BCC_RST_ZERO;
      if (rd_i)
      begin
         case (addr_i)
            `BCC_OFF_MODE: rdata_d = mode_q;
            `BCC_OFF_HFMT: rdata_d = {31'h00000000, hfmt_q};
            `BCC_OFF_TIME: rdata_d = time_rd;
            `BCC_OFF_CAL: rdata_d = cal_rd;
            `BCC_OFF_TALM: rdata_d = talm_q;
            `BCC_OFF_CALM: rdata_d = calm_q;
            `BCC_OFF_STAT: rdata_d = {27'h0000000, stat_q};
            `BCC_OFF_IMSK: rdata_d = {27'h0000000, imsk_q};
            `BCC_OFF_VER: rdata_d = {28'h0000000, ver_q};
            default: rdata_d = `BCC_RST_ZERO;
         endcase
      end
   end

   assign rdata_o = rdata_q;

endmodule

// [bcc_calendar_clock_asserts.sv]
`timescale 1ns/1ps
`include "bcc_regs.vh"

module bcc_regs_checker #(
   parameter TICK_CYCLES = 8
)(
   input wire core_clk_i,
   input wire rst_n_i,
   input wire en_i,
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o
);
   // ==========================================================
   // shadow of request bits, seen from the bus only
   reg [1:0] upd_q;
   reg cal_fresh_q;
   wire wr_ok;
   wire rd_ok;
   assign wr_ok = en_i && wr_i;
   assign rd_ok = en_i && rd_i;
   always @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         upd_q <= 2'h0;
         cal_fresh_q <= 1'b1;
      end
      else if (wr_ok)
      begin
         if (addr_i == `BCC_OFF_MODE)
            upd_q <= wdata_i[1:0];
         // a midnight crossing needs a time write first, so both count
         if (addr_i == `BCC_OFF_TIME || addr_i == `BCC_OFF_CAL)
            cal_fresh_q <= 1'b0;
      end
   end

   // ==========================================================
   // properties
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_idle_read_zero: assert property ($past(en_i) && !$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data not zero outside a read");
   a_mode_read_back: assert property (wr_ok && addr_i == `BCC_OFF_MODE ##1
      rd_ok && addr_i == `BCC_OFF_MODE |=> rdata_o == ($past(wdata_i, 2) & `BCC_MASK_MODE))
      else $error("mode register read back wrong");
   a_hfmt_read_back: assert property (wr_ok && addr_i == `BCC_OFF_HFMT ##1
      rd_ok && addr_i == `BCC_OFF_HFMT |=> rdata_o == ($past(wdata_i, 2) & 32'h1))
      else $error("hour format read back wrong");
   a_cal_reset_val: assert property (rd_ok && addr_i == `BCC_OFF_CAL && cal_fresh_q
      |=> rdata_o == `BCC_RST_CAL)
      else $error("calendar reset value wrong");
   a_ack_on_request: assert property (wr_ok && addr_i == `BCC_OFF_MODE && wdata_i[0]
      && !upd_q[0] ##1 rd_ok && addr_i == `BCC_OFF_STAT |=> rdata_o[`BCC_ST_ACK])
      else $error("update acknowledge missing");
   a_bad_entry_flag: assert property (wr_ok && addr_i == `BCC_OFF_TIME && upd_q[0]
      && wdata_i[3:0] > 4'h9 ##1 rd_ok && addr_i == `BCC_OFF_VER |=> rdata_o[`BCC_VER_TIME])
      else $error("time entry error not flagged");
   a_wo_read_zero: assert property (rd_ok && (addr_i == `BCC_OFF_SCLR
      || addr_i == `BCC_OFF_IEN || addr_i == `BCC_OFF_IDIS || addr_i >= 8'h30)
      |=> rdata_o == 32'h0)
      else $error("write-only or unmapped read not zero");
   a_mask_set_bits: assert property (wr_ok && addr_i == `BCC_OFF_IEN ##1
      rd_ok && addr_i == `BCC_OFF_IMSK
      |=> (rdata_o & $past(wdata_i, 2) & 32'h1f) == ($past(wdata_i, 2) & 32'h1f))
      else $error("mask bits not set");
   a_mask_clr_bits: assert property (wr_ok && addr_i == `BCC_OFF_IDIS ##1
      rd_ok && addr_i == `BCC_OFF_IMSK |=> (rdata_o & $past(wdata_i, 2)) == 32'h0)
      else $error("mask bits not cleared");

   c_time_write: cover property (wr_ok && addr_i == `BCC_OFF_TIME && upd_q[0]);
   c_alarm_seen: cover property (rd_ok && addr_i == `BCC_OFF_STAT ##1 rdata_o[`BCC_ST_ALARM]);
   c_cal_event: cover property (rd_ok && addr_i == `BCC_OFF_STAT ##1 rdata_o[`BCC_ST_CEV]);
endmodule

bind bcc_calendar_clock bcc_regs_checker #(.TICK_CYCLES(TICK_CYCLES)) i_bcc_regs_checker (
   .core_clk_i(core_clk_i),
   .rst_n_i(rst_n_i),
   .en_i(en_i),
   .addr_i(addr_i),
   .wdata_i(wdata_i),
   .wr_i(wr_i),
   .rd_i(rd_i),
   .rdata_o(rdata_o)
);

// [tb_top.sv]
`timescale 1ns/1ps

module tb_top;
   localparam logic [31:0] C0 = 32'h01819819;
   logic core_clk_i;
   logic rst_n_i = 1'b0;
   logic en_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   wire [31:0] rdata_o;
   logic pend_q = 1'b0;
   logic [71:0] ent;
   logic [71:0] exp_q [$];
   int mismatches = 0;
   int cmp_count = 0;
   int i;
   logic [31:0] rt;
   logic [7:0] ra [0:12] = '{8'h08, 8'h18, 8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h28,
      8'h2c, 8'h1c, 8'h20, 8'h24, 8'h30};
   // hfmt, mode, time, cal, alarm, status mask, status, time after, cal after
   logic [31:0] tab [0:16][0:8] = '{
      '{1'h0, 12'h000, 24'h000059, C0, 1'h0, 8'h08, 8'h08, 24'h000100, C0},
      '{1'h0, 12'h100, 24'h005959, C0, 1'h0, 8'h08, 8'h08, 24'h010000, C0},
      '{1'h0, 12'h200, 24'h115959, C0, 1'h0, 8'h08, 8'h00, 24'h120000, C0},
      '{1'h0, 12'h200, 24'h235959, C0, 1'h0, 8'h08, 8'h08, 24'h0, 32'h02a19819},
      '{1'h0, 12'h300, 24'h115959, C0, 1'h0, 8'h08, 8'h08, 24'h120000, C0},
      '{1'h0, 20'h0, 24'h235959, 32'h05e19819, 1'h0, 8'h10, 8'h10, 24'h0, 32'h06219819},
      '{1'h0, 20'h10000, 24'h235959, 32'h31819819, 1'h0, 8'h10, 8'h10, 24'h0, 32'h01a29819},
      '{1'h0, 20'h20000, 24'h235959, 32'h31929819, 1'h0, 8'h10, 8'h10, 24'h0, 32'h01a19919},
      '{1'h0, 20'h20002, 24'h235959, 32'h31929819, 1'h0, 8'h10, 8'h0, 24'h0, 32'h31929819},
      '{1'h1, 12'h000, 24'h115959, C0, 1'h0, 8'h00, 8'h00, 24'h520000, C0},
      '{1'h1, 12'h000, 24'h525959, C0, 1'h0, 8'h00, 8'h00, 24'h410000, C0},
      '{1'h1, 12'h200, 24'h515959, C0, 1'h0, 8'h08, 8'h08, 24'h120000, 32'h02a19819},
      '{1'h0, 12'h000, 24'h000050, C0, 24'h0033d2, 8'h02, 8'h02, 24'h0, C0},
      '{1'h0, 12'h000, 24'h000050, C0, 24'h00b3d2, 8'h02, 8'h00, 24'h0, C0},
      '{1'h0, 12'h000, 24'h000050, C0, 24'h8080d2, 8'h02, 8'h02, 24'h0, C0},
      '{1'h1, 12'h000, 24'h520050, C0, 24'hd200d2, 8'h02, 8'h02, 24'h520000, C0},
      '{1'h1, 12'h000, 24'h520050, C0, 24'h9200d2, 8'h02, 8'h00, 24'h520000, C0}};
   // address, refused value, error bit, accepted value
   logic [31:0] bad [0:9][0:3] = '{
      '{8'h08, 24'h00005a, 4'h1, 24'h123456},
      '{8'h08, 24'h006000, 4'h1, 24'h123456},
      '{8'h08, 24'h240000, 4'h1, 24'h123456},
      '{8'h08, 24'h410000, 4'h1, 24'h123456},
      '{8'h0c, 32'h01819821, 4'h2, 32'h15a49920},
      '{8'h0c, 32'h01939819, 4'h2, 32'h15a49920},
      '{8'h0c, 32'h32819819, 4'h2, 32'h15a49920},
      '{8'h0c, 32'h01019819, 4'h2, 32'h15a49920},
      '{8'h10, 24'h000060, 4'h4, 24'ha3b4c5},
      '{8'h10, 24'h400000, 4'h4, 24'ha3b4c5}};

   bcc_calendar_clock #(.TICK_CYCLES(8)) i_bcc_calendar_clock (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .en_i(en_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o)
   );

   // ==========================================================
   // bus tasks; strobes stay up so accesses run back to back
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      rd_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge core_clk_i);
      addr_i <= a;
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      exp_q.push_back({a, m, e & m});
   endtask
   task automatic idle(input int n);
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (n - 1) @(posedge core_clk_i);
   endtask
   function automatic logic [7:0] rnd(input int n);
      int v;
      v = $urandom % n;
      rnd = 8'(((v / 10) << 4) | (v % 10));
   endfunction

   // ==========================================================
   // checking
   task automatic check(input logic [7:0] a, input logic [31:0] seen, input logic [31:0] e);
      cmp_count++;
      if (seen !== e)
      begin
         mismatches++;
         $display("BAD reg %h expected %h seen %h", a, e, seen);
      end
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge core_clk_i)
   begin
      if (pend_q)
      begin
         ent = exp_q.pop_front();
         check(ent[71:64], rdata_o & ent[63:32], ent[31:0]);
      end
      pend_q <= rd_i && en_i;
   end

   // ==========================================================
   // stimulus
   initial
   begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      mismatches++;
      report_and_stop;
   end
   initial
   begin
      void'($urandom(59));
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      for (i = 0; i < 13; i++)
         rd(ra[i], (ra[i] == 8'h0c) ? C0 : 32'h0, 32'hffffffff);
      wr(8'h00, 32'h20301);
      rd(8'h00, 32'h20301, 32'hffffffff);
      wr(8'h00, 32'h0);
      idle(1);
      // a strobe with the enable low must not land
      en_i <= 1'b0;
      wr(8'h04, 32'h1);
      idle(1);
      en_i <= 1'b1;
      rd(8'h04, 32'h0, 32'hffffffff);
      wr(8'h04, 32'h1);
      rd(8'h04, 32'h1, 32'hffffffff);
      wr(8'h20, 32'h1f);
      rd(8'h28, 32'h1f, 32'hffffffff);
      wr(8'h24, 32'h05);
      rd(8'h28, 32'h1a, 32'hffffffff);
      wr(8'h28, 32'h0);
      wr(8'h18, 32'h1f);
      rd(8'h28, 32'h1a, 32'hffffffff);
      for (i = 0; i < 17; i++)
      begin
         wr(8'h04, tab[i][0]);
         wr(8'h00, tab[i][1] | 32'h3);
         rd(8'h18, 32'h1, 32'h1);
         wr(8'h1c, 32'h1f);
         wr(8'h08, tab[i][2]);
         wr(8'h0c, tab[i][3]);
         wr(8'h10, tab[i][4]);
         wr(8'h00, tab[i][1]);
         idle(30);
         rd(8'h18, tab[i][6], tab[i][5]);
         rd(8'h08, tab[i][7], 32'hffffff00);
         rd(8'h0c, tab[i][8], 32'hffffffff);
      end
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h3);
      for (i = 0; i < 10; i++)
      begin
         wr(bad[i][0], bad[i][3]);
         wr(bad[i][0], bad[i][1]);
         rd(8'h2c, bad[i][2], bad[i][2]);
         rd(bad[i][0], bad[i][3], 32'hffffffff);
         wr(bad[i][0], bad[i][3]);
         rd(8'h2c, 32'h0, bad[i][2]);
      end
      rt = {8'h00, rnd(23), rnd(60), rnd(50)};
      wr(8'h08, rt);
      wr(8'h0c, 32'h15a49920);
      wr(8'h00, 32'h0);
      wr(8'h08, 32'h00235959);
      wr(8'h0c, C0);
      rd(8'h08, rt, 32'hffff00);
      rd(8'h0c, 32'h15a49920, 32'hffffffff);
      idle(4);
      report_and_stop;
   end
endmodule
